/* rtl/aofc_pkg.sv */
// Constants for the ADC output format control register bank.
// Assumes a byte-wide register write/read port driven by the serial interface decoder.
package aofc_pkg;
    localparam logic [7:0] ADDR_WIDTH_DRIVE = 8'h63;
    localparam logic [7:0] ADDR_PHASE       = 8'h64;
    localparam logic [7:0] ADDR_POLARITY    = 8'h65;
    localparam logic [7:0] ADDR_OFFSET_LO   = 8'h66;
    localparam logic [7:0] ADDR_OFFSET_HI   = 8'h67;
    localparam logic [7:0] ADDR_FRAME_AUX   = 8'h68;
    localparam logic [7:0] ADDR_PLL_CAL     = 8'h6b;

    localparam logic [7:0] RST_WIDTH_DRIVE  = 8'h01;
    localparam logic [7:0] RST_PHASE        = 8'h03;
    localparam logic [7:0] RST_POLARITY     = 8'h00;
    localparam logic [7:0] RST_OFFSET       = 8'h00;
    localparam logic [7:0] RST_FRAME_AUX    = 8'h24;
    localparam logic [7:0] RST_PLL_CAL      = 8'h08;

    localparam int WIDTH_LSB       = 4;
    localparam int TERM_BIT        = 3;
    localparam int DRIVE_LSB       = 0;
    localparam int PHASE_EN_BIT    = 7;
    localparam int PHASE_SEL_LSB   = 4;
    localparam int FRAME_INV_BIT   = 3;
    localparam int FRAME_EN_BIT    = 2;
    localparam int AUX_ADD_BIT     = 1;
    localparam int AUX_INV_BIT     = 0;
    localparam int CAL_TRIG_BIT    = 2;

    localparam logic [3:0] WIDTH_CODE_FULL = 4'h0;
    localparam logic [4:0] RES_12          = 5'h0c;
    localparam logic [4:0] RES_14          = 5'h0e;
    localparam logic [4:0] RES_16          = 5'h10;
    localparam logic [4:0] RES_18          = 5'h12;

    // Offset shift applied to a fixed 19-bit fraction grid (three fractional bits below 16-bit LSb).
    localparam logic [1:0] OFS_SH_12 = 2'h0;
    localparam logic [1:0] OFS_SH_14 = 2'h1;
    localparam logic [1:0] OFS_SH_16 = 2'h2;
    localparam logic [1:0] OFS_SH_18 = 2'h3;

    localparam logic [2:0] MIN_SHIFT_DECIM = 3'h2;

    typedef enum logic [1:0] {
        AOFC_OUT_OFF  = 2'h0,
        AOFC_OUT_CMOS = 2'h1,
        AOFC_OUT_LVDS = 2'h3
    } aofc_mode_type;
endpackage : aofc_pkg

/* rtl/aofc_regs.sv */
// Output format control register bank with the derived data-path controls.
// Assumes one-cycle write strobes from the serial interface decoder and an output formatter that
// consumes the decoded controls; the caller keeps factory bits unchanged.
`timescale 1ns/1ps
module aofc_regs (
    input  wire logic                  REF_CLK_I,          // Device clock, 50 MHz.
    input  wire logic                  RESET_I,            // Synchronous reset, active high.
    input  wire logic                  WR_EN_I,            // One-cycle register write strobe.
    input  wire logic [7:0]            ADDR_I,             // Register address.
    input  wire logic [7:0]            WDATA_I,            // Write data.
    output      logic [7:0]            RDATA_O,            // Read data for ADDR_I, registered.
    input  wire logic                  LVDS_MODE_I,        // High while LVDS output mode is selected.
    input  wire logic [2:0]            DECIM_LOG2_I,       // Decimation factor as power of two, 0 none.
    input  wire logic                  DEFAULT_FILTERS_I,  // High while filter settings are at default.
    output      logic [4:0]            RESOLUTION_O,       // Effective output bits, 1 to 18.
    output      logic                  TERM_EN_O,          // Internal LVDS termination enable.
    output      logic [2:0]            DRIVE_CURRENT_SEL_O,// LVDS drive current code.
    output      logic                  PHASE_SHIFT_EN_O,   // Decimated clock phase shift active.
    output      logic [2:0]            DECIM_CLK_PHASE_SEL_O, // Phase in 45 degree steps.
    output      logic [7:0]            PAIR_INVERT_MASK_O, // Effective per-pair inversion mask.
    output      logic [15:0]           GLOBAL_OFFSET_VALUE_O, // Raw two's complement offset.
    output      logic [1:0]            OFFSET_SHIFT_O,     // Offset scale: count << shift on 1/8 LSb grid.
    output      logic                  FRAME_OVR_OUT_EN_O, // Word clock and overrange pair enable.
    output      logic                  FRAME_OVR_INVERT_O, // Word clock and overrange pair inversion.
    output      logic                  AUX_LSB_ADD_O,      // Two auxiliary LSbs appended.
    output      logic                  AUX_LSB_INVERT_O,   // Auxiliary pair inversion.
    output      logic                  SYNTH_CAL_START_O   // One-cycle PLL calibration start pulse.
);
    import aofc_pkg::*;

    logic [7:0] width_drive_q;
    logic [7:0] phase_q;
    logic [7:0] polarity_q;
    logic [7:0] offset_lo_q;
    logic [7:0] offset_hi_q;
    logic [7:0] frame_aux_q;
    logic [7:0] pll_cal_q;
    logic       cal_start_q;
    logic [4:0] base_res;
    logic [3:0] width_code;
    logic       aux_active;
    logic       phase_allowed;

    //////////////////////////////////////////////////////////////////////////////////////////////
    // Register writes.
    always_ff @(posedge REF_CLK_I) begin
        if (RESET_I) begin
            width_drive_q <= RST_WIDTH_DRIVE;
            phase_q       <= RST_PHASE;
            polarity_q    <= RST_POLARITY;
            offset_lo_q   <= RST_OFFSET;
            offset_hi_q   <= RST_OFFSET;
            frame_aux_q   <= RST_FRAME_AUX;
            pll_cal_q     <= RST_PLL_CAL;
        end else if (WR_EN_I) begin
            case (ADDR_I)
                ADDR_WIDTH_DRIVE: width_drive_q <= WDATA_I;
                ADDR_PHASE:       phase_q       <= WDATA_I;
                ADDR_POLARITY:    polarity_q    <= WDATA_I;
                ADDR_OFFSET_LO:   offset_lo_q   <= WDATA_I;
                ADDR_OFFSET_HI:   offset_hi_q   <= WDATA_I;
                ADDR_FRAME_AUX:   frame_aux_q   <= WDATA_I;
                ADDR_PLL_CAL:     pll_cal_q     <= WDATA_I;
                default: begin
                end
            endcase
        end
    end

    // A toggle in either direction starts calibration; a rewrite of the same value does not.
    always_ff @(posedge REF_CLK_I) begin
        if (RESET_I) begin
            cal_start_q <= 1'b0;
        end else begin
            cal_start_q <= WR_EN_I && (ADDR_I == ADDR_PLL_CAL) &&
                           (WDATA_I[CAL_TRIG_BIT] != pll_cal_q[CAL_TRIG_BIT]);
        end
    end

    always_ff @(posedge REF_CLK_I) begin
        if (RESET_I) begin
            RDATA_O <= 8'h00;
        end else begin
            case (ADDR_I)
                ADDR_WIDTH_DRIVE: RDATA_O <= width_drive_q;
                ADDR_PHASE:       RDATA_O <= phase_q;
                ADDR_POLARITY:    RDATA_O <= polarity_q;
                ADDR_OFFSET_LO:   RDATA_O <= offset_lo_q;
                ADDR_OFFSET_HI:   RDATA_O <= offset_hi_q;
                ADDR_FRAME_AUX:   RDATA_O <= frame_aux_q;
                ADDR_PLL_CAL:     RDATA_O <= pll_cal_q;
                default:          RDATA_O <= 8'h00;
            endcase
        end
    end

    //////////////////////////////////////////////////////////////////////////////////////////////
    // Decoded controls.
    assign width_code = width_drive_q[WIDTH_LSB +: 4];
    assign base_res   = (width_code == WIDTH_CODE_FULL) ? RES_16 : {1'b0, width_code};
    // Extra LSbs only exist on the full 16-bit word and only while decimating.
    assign aux_active = frame_aux_q[AUX_ADD_BIT] && (base_res == RES_16) &&
                        (DECIM_LOG2_I != 3'h0);
    assign RESOLUTION_O = aux_active ? RES_18 : base_res;
    assign AUX_LSB_ADD_O = aux_active;

    assign TERM_EN_O           = width_drive_q[TERM_BIT];
    assign DRIVE_CURRENT_SEL_O = width_drive_q[DRIVE_LSB +: 3];

    // Even 45 degree codes are not offered with default filters, so they fall back to reference.
    assign phase_allowed = (DECIM_LOG2_I >= MIN_SHIFT_DECIM) &&
                           (!DEFAULT_FILTERS_I || phase_q[PHASE_SEL_LSB]);
    assign PHASE_SHIFT_EN_O      = phase_q[PHASE_EN_BIT] && phase_allowed;
    assign DECIM_CLK_PHASE_SEL_O = PHASE_SHIFT_EN_O ? phase_q[PHASE_SEL_LSB +: 3] : 3'h0;

    always_comb begin
        PAIR_INVERT_MASK_O = polarity_q;
        if (RESOLUTION_O == RES_14) begin
            PAIR_INVERT_MASK_O[0] = 1'b0;
        end else if (RESOLUTION_O == RES_12) begin
            PAIR_INVERT_MASK_O[1:0] = 2'h0;
        end
    end

    assign GLOBAL_OFFSET_VALUE_O = {offset_hi_q, offset_lo_q};

    always_comb begin
        case (RESOLUTION_O)
            RES_12:  OFFSET_SHIFT_O = OFS_SH_12;
            RES_14:  OFFSET_SHIFT_O = OFS_SH_14;
            RES_18:  OFFSET_SHIFT_O = OFS_SH_18;
            default: OFFSET_SHIFT_O = OFS_SH_16;
        endcase
    end

    assign FRAME_OVR_OUT_EN_O = frame_aux_q[FRAME_EN_BIT];
    assign FRAME_OVR_INVERT_O = LVDS_MODE_I && frame_aux_q[FRAME_INV_BIT];
    assign AUX_LSB_INVERT_O   = LVDS_MODE_I && frame_aux_q[AUX_INV_BIT];
    assign SYNTH_CAL_START_O  = cal_start_q;
endmodule : aofc_regs

/* bench/aofc_rx_model.sv */
// Far-side capture model: counts calibration start pulses.
// Assumes the pulse is synchronous to the device clock.
`timescale 1ns/1ps
module aofc_rx_model (
    input  wire logic clk_i,   // Device clock.
    input  wire logic rst_i,   // Synchronous reset.
    input  wire logic cal_i,   // Calibration start pulse.
    output int        count_o  // Pulses seen.
);
    always_ff @(posedge clk_i) begin
        if (rst_i) count_o <= 0;
        else if (cal_i) count_o <= count_o + 1;
    end
endmodule : aofc_rx_model

/* bench/aofc_regs_assertions.sv */
// Port checker for the output format register bank.
// Assumes it is bound to aofc_regs.
`timescale 1ns/1ps
module aofc_regs_assertions
    import aofc_pkg::*;
(
    input wire logic       REF_CLK_I, RESET_I, WR_EN_I, LVDS_MODE_I, DEFAULT_FILTERS_I, // Watched inputs.
    input wire logic [7:0] ADDR_I, WDATA_I, PAIR_INVERT_MASK_O,                        // Bus and mask.
    input wire logic [2:0] DECIM_LOG2_I, DRIVE_CURRENT_SEL_O, DECIM_CLK_PHASE_SEL_O,   // Codes.
    input wire logic [4:0] RESOLUTION_O,                                               // Resolution.
    input wire logic       TERM_EN_O, PHASE_SHIFT_EN_O, FRAME_OVR_INVERT_O,            // Controls.
    input wire logic       AUX_LSB_INVERT_O, SYNTH_CAL_START_O                         // Controls.
);
    default clocking cb @(posedge REF_CLK_I); endclocking
    default disable iff (RESET_I);
    sequence s_wr63; WR_EN_I && ADDR_I == ADDR_WIDTH_DRIVE; endsequence
    property p_width; s_wr63 ##0 WDATA_I[7:4] != 4'h0 |=> RESOLUTION_O == {1'b0, $past(WDATA_I[7:4])}; endproperty
    property p_term; s_wr63 |=> TERM_EN_O == $past(WDATA_I[3]); endproperty
    property p_drive; s_wr63 |=> DRIVE_CURRENT_SEL_O == $past(WDATA_I[2:0]); endproperty
    property p_phase_off; !PHASE_SHIFT_EN_O |-> DECIM_CLK_PHASE_SEL_O == 3'h0; endproperty
    property p_phase_decim; PHASE_SHIFT_EN_O |-> DECIM_LOG2_I > 3'h1; endproperty
    property p_phase_odd; PHASE_SHIFT_EN_O && DEFAULT_FILTERS_I |-> DECIM_CLK_PHASE_SEL_O[0]; endproperty
    property p_mask12; RESOLUTION_O == RES_12 |-> PAIR_INVERT_MASK_O[1:0] == 2'h0; endproperty
    property p_frame_inv; FRAME_OVR_INVERT_O |-> LVDS_MODE_I; endproperty
    property p_aux_inv; AUX_LSB_INVERT_O |-> LVDS_MODE_I; endproperty
    property p_cal; SYNTH_CAL_START_O |-> $past(WR_EN_I) && $past(ADDR_I) == ADDR_PLL_CAL; endproperty
    a_width: assert property (p_width) else $error("width mismatch");
    a_term: assert property (p_term) else $error("termination mismatch");
    a_drive: assert property (p_drive) else $error("drive mismatch");
    a_phase_off: assert property (p_phase_off) else $error("phase not at reference");
    a_phase_decim: assert property (p_phase_decim) else $error("shift without decimation");
    a_phase_odd: assert property (p_phase_odd) else $error("even phase offered");
    a_mask12: assert property (p_mask12) else $error("low mask bits kept");
    a_frame_inv: assert property (p_frame_inv) else $error("frame inverted outside lvds");
    a_aux_inv: assert property (p_aux_inv) else $error("aux inverted outside lvds");
    a_cal: assert property (p_cal) else $error("stray calibration pulse");
endmodule : aofc_regs_assertions

/* bench/aofc_regs_test.sv */
// Self-checking bench for the output format register bank.
// Assumes inputs change 1 ns after the rising edge.
`timescale 1ns/1ps
module aofc_regs_test;
    import aofc_pkg::*;
    logic clk = 0, rst = 1, we = 0, lvds = 0, filt = 1;
    logic [7:0] addr = 0, wdat = 0;
    logic [2:0] dlog = 0;
    wire logic [7:0] rdat, mask;
    wire logic [4:0] res;
    wire logic [2:0] drv, psel;
    wire logic [15:0] ofs;
    wire logic [1:0] sh;
    wire logic term, pen, fen, finv, aadd, ainv, cal;
    int fail_count = 0, total_checks = 0, cal_count;
    aofc_regs i_dut (.REF_CLK_I(clk), .RESET_I(rst), .WR_EN_I(we), .ADDR_I(addr), .WDATA_I(wdat),
        .RDATA_O(rdat), .LVDS_MODE_I(lvds), .DECIM_LOG2_I(dlog), .DEFAULT_FILTERS_I(filt),
        .RESOLUTION_O(res), .TERM_EN_O(term), .DRIVE_CURRENT_SEL_O(drv), .PHASE_SHIFT_EN_O(pen),
        .DECIM_CLK_PHASE_SEL_O(psel), .PAIR_INVERT_MASK_O(mask), .GLOBAL_OFFSET_VALUE_O(ofs),
        .OFFSET_SHIFT_O(sh), .FRAME_OVR_OUT_EN_O(fen), .FRAME_OVR_INVERT_O(finv),
        .AUX_LSB_ADD_O(aadd), .AUX_LSB_INVERT_O(ainv), .SYNTH_CAL_START_O(cal));
    aofc_rx_model i_rx (.clk_i(clk), .rst_i(rst), .cal_i(cal), .count_o(cal_count));
    task automatic chk(string n, logic [15:0] e, logic [15:0] g);
        total_checks++;
        if (g !== e) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic wr(logic [7:0] a, logic [7:0] d);
        addr = a;
        wdat = d;
        we = 1;
        @(posedge clk);
        #1 we = 0;
        // One idle edge keeps back-to-back calls from lowering and raising the strobe in one step.
        @(posedge clk);
        #1;
    endtask : wr
    task automatic rd(logic [7:0] a, logic [7:0] e);
        addr = a;
        @(posedge clk);
        #1 chk("rdata", e, rdat);
    endtask : rd
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : wrap_up
    initial forever #10 clk = ~clk;
    initial begin
        #200000 fail_count++;
        wrap_up();
    end
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        logic [7:0] ra[7] = '{8'h63, 8'h64, 8'h65, 8'h66, 8'h67, 8'h68, 8'h6b};
        logic [7:0] rv[7] = '{RST_WIDTH_DRIVE, RST_PHASE, 8'h00, 8'h00, 8'h00, RST_FRAME_AUX, RST_PLL_CAL};
        logic [2:0] dc[4] = '{3'h7, 3'h3, 3'h1, 3'h0};
        logic [3:0] wc[3] = '{4'hc, 4'he, 4'h0};
        logic [7:0] wm[3] = '{8'h80, 8'h82, 8'h83};
        repeat (4) @(posedge clk);
        #1 rst = 0;
        chk("frame enable", 1, fen);
        foreach (ra[i]) rd(ra[i], rv[i]);
        rd(8'h69, 8'h00);
        for (int c = 0; c < 16; c++) begin
            wr(ADDR_WIDTH_DRIVE, {c[3:0], c[0], 3'h1});
            chk("width term", {c == 0 ? 5'h10 : c[4:0], c[0]}, {res, term});
        end
        foreach (dc[i]) begin
            wr(ADDR_WIDTH_DRIVE, {5'h0, dc[i]});
            chk("drive", dc[i], drv);
        end
        dlog = 3'h2;
        for (int f = 0; f < 2; f++) for (int c = 0; c < 8; c++) begin
            filt = f[0];
            wr(ADDR_PHASE, {1'b1, c[2:0], 4'h3});
            chk("phase", (f == 0 || c[0]) ? 8 + c : 0, {pen, psel});
        end
        wr(ADDR_PHASE, 8'h53);
        chk("phase off", 0, {pen, psel});
        dlog = 3'h1;
        wr(ADDR_PHASE, 8'hd3);
        chk("phase low decim", 0, {pen, psel});
        wr(ADDR_POLARITY, 8'h83);
        foreach (wc[i]) begin
            wr(ADDR_WIDTH_DRIVE, {wc[i], 4'h1});
            chk("mask shift", {wm[i], 6'h0, i[1:0]}, {mask, 6'h0, sh});
        end
        wr(ADDR_OFFSET_LO, 8'h34);
        wr(ADDR_OFFSET_HI, 8'h92);
        chk("offset", 16'h9234, ofs);
        for (int m = 0; m < 32; m++) begin
            lvds = m[4];
            wr(ADDR_FRAME_AUX, {4'h2, m[3:0]});
            chk("frame aux", {m[2], m[3] & m[4], m[1], m[0] & m[4], m[1] ? 7'h4b : 7'h42},
                {fen, finv, aadd, ainv, res, sh});
        end
        dlog = 3'h0;
        @(posedge clk);
        #1 chk("no decim res", 5'h10, res);
        wr(ADDR_PLL_CAL, 8'h0c);
        wr(ADDR_PLL_CAL, 8'h0c);
        wr(ADDR_PLL_CAL, 8'h08);
        wr(ADDR_PLL_CAL, 8'h0c);
        repeat (2) @(posedge clk);
        #1 chk("cal pulses", 3, cal_count[15:0]);
        rd(ADDR_PLL_CAL, 8'h0c);
        // A second reset in mid-run must bring the written registers back to their power-on values.
        rst = 1;
        @(posedge clk);
        #1 rst = 0;
        rd(ADDR_PLL_CAL, RST_PLL_CAL);
        chk("offset after reset", 16'h0000, ofs);
        wrap_up();
    end
endmodule : aofc_regs_test
bind aofc_regs aofc_regs_assertions i_chk (.*);
